// ---- logic/rmpc_map.svh ----
`ifndef RMPC_MAP_SVH
`define RMPC_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RMPC_OFS_CTRL 12'h000
`define RMPC_OFS_DEPTH 12'h004
`define RMPC_OFS_FOCAL 12'h008
`define RMPC_OFS_CENTER 12'h00c
`define RMPC_OFS_FRM_DLY 12'h010
`define RMPC_OFS_PKT_GAP 12'h014
`define RMPC_OFS_STATUS 12'h018

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RMPC_CTRL_RECT 0
`define RMPC_CTRL_CH_LO 1
`define RMPC_CTRL_CH_HI 2
`define RMPC_CTRL_SYNC 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RMPC_RST_LOWER 16'h0000
`define RMPC_RST_UPPER 16'h1b58
`define RMPC_RST_FOCAL 16'h0100
`define RMPC_RST_CX 16'h0140
`define RMPC_RST_CY 16'h00f0
`define RMPC_RST_FRM_DLY 32'h0000_0000
`define RMPC_RST_PKT_GAP 16'h0000
`define RMPC_RST_CH 2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RMPC_CLK_PERIOD_NS 5
`define RMPC_TICK_NS 1
`define RMPC_TICKS_PER_CLK (`RMPC_CLK_PERIOD_NS / `RMPC_TICK_NS)
`define RMPC_ILLUM_DIV 10
`define RMPC_FULL_SCALE 16'hffff

`endif

// ---- logic/rmpc_pkg.sv ----
`default_nettype none

package rmpc_pkg;

  // Frame transmit scheduler states.
  typedef enum logic [1:0] {
    RMPC_TX_IDLE = 2'b00,
    RMPC_TX_DELAY = 2'b01,
    RMPC_TX_START = 2'b10
  } rmpc_tx_state_t;

  typedef logic [15:0] rmpc_word16_t;
  typedef logic [1:0] rmpc_chan_t;

endpackage : rmpc_pkg

`default_nettype wire

// ---- logic/rmpc_top.sv ----
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rmpc_map.svh"

module rmpc_top (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Session control.
  input wire logic i_conn_close,
  // Pixel input stream.
  input wire logic i_pix_valid,
  input wire logic i_pix_sof,
  input wire rmpc_pkg::rmpc_word16_t i_pix_data,
  input wire rmpc_pkg::rmpc_word16_t i_pix_col,
  input wire rmpc_pkg::rmpc_word16_t i_pix_row,
  // Pixel output stream.
  output logic o_pix_valid,
  output rmpc_pkg::rmpc_word16_t o_range_mm,
  output logic [7:0] o_red,
  output logic [7:0] o_green,
  output logic [7:0] o_blue,
  output logic o_xyz_valid,
  output logic signed [31:0] o_x,
  output logic signed [31:0] o_y,
  output logic [31:0] o_z,
  // Transmit pacing.
  input wire logic i_frame_done,
  input wire logic i_pkt_sent,
  output logic o_frame_tx_start,
  output logic o_pkt_go,
  // Illumination.
  output logic o_illum_pulse
);
  import rmpc_pkg::*;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  logic rect_en;
  rmpc_chan_t illum_chan;
  logic time_sync_enable;
  rmpc_word16_t depth_lower_bound;
  rmpc_word16_t depth_upper_bound;
  rmpc_word16_t focal_len;
  rmpc_word16_t center_x;
  rmpc_word16_t center_y;
  logic [31:0] frm_delay;
  rmpc_word16_t pkt_gap;
  logic [15:0] frame_count;
  rmpc_tx_state_t tx_state;

  logic wr_acc;
  logic rd_setup;
  assign wr_acc = i_psel & i_penable & i_pwrite & o_pready;
  assign rd_setup = i_psel & ~i_penable;

  // Address decode shared by the read and write paths.
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `RMPC_OFS_CTRL) || (a == `RMPC_OFS_DEPTH) ||
                (a == `RMPC_OFS_FOCAL) || (a == `RMPC_OFS_CENTER) ||
                (a == `RMPC_OFS_FRM_DLY) || (a == `RMPC_OFS_PKT_GAP) ||
                (a == `RMPC_OFS_STATUS);
  endfunction : is_mapped

  // Session settings; a connection close restores them, power loss too.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rect_en <= 1'b0;
      illum_chan <= `RMPC_RST_CH;
      depth_lower_bound <= `RMPC_RST_LOWER;
      depth_upper_bound <= `RMPC_RST_UPPER;
      focal_len <= `RMPC_RST_FOCAL;
      center_x <= `RMPC_RST_CX;
      center_y <= `RMPC_RST_CY;
      frm_delay <= `RMPC_RST_FRM_DLY;
      pkt_gap <= `RMPC_RST_PKT_GAP;
    end else if (i_conn_close) begin
      rect_en <= 1'b0;
      illum_chan <= `RMPC_RST_CH;
      depth_lower_bound <= `RMPC_RST_LOWER;
      depth_upper_bound <= `RMPC_RST_UPPER;
      focal_len <= `RMPC_RST_FOCAL;
      center_x <= `RMPC_RST_CX;
      center_y <= `RMPC_RST_CY;
      frm_delay <= `RMPC_RST_FRM_DLY;
      pkt_gap <= `RMPC_RST_PKT_GAP;
    end else if (wr_acc) begin
      unique case (i_paddr)
        `RMPC_OFS_CTRL: begin
          rect_en <= i_pwdata[`RMPC_CTRL_RECT];
          illum_chan <= i_pwdata[`RMPC_CTRL_CH_HI:`RMPC_CTRL_CH_LO];
        end
        `RMPC_OFS_DEPTH: begin
          depth_lower_bound <= i_pwdata[15:0];
          depth_upper_bound <= i_pwdata[31:16];
        end
        `RMPC_OFS_FOCAL: focal_len <= i_pwdata[15:0];
        `RMPC_OFS_CENTER: begin
          center_x <= i_pwdata[15:0];
          center_y <= i_pwdata[31:16];
        end
        `RMPC_OFS_FRM_DLY: frm_delay <= i_pwdata;
        `RMPC_OFS_PKT_GAP: pkt_gap <= i_pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Time sync enable survives a connection close; only reset or a CTRL write with bit 3 low clears it.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      time_sync_enable <= 1'b0;
    end else if (wr_acc && i_paddr == `RMPC_OFS_CTRL) begin
      time_sync_enable <= i_pwdata[`RMPC_CTRL_SYNC];
    end
  end

  // --------------------------------------------------------------------
  // APB answer: zero wait states, data captured in the setup cycle
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= rd_setup;
      o_pslverr <= rd_setup & ~is_mapped(i_paddr);
      if (rd_setup && !i_pwrite) begin
        unique case (i_paddr)
          `RMPC_OFS_CTRL: o_prdata <= {28'h0000000, time_sync_enable,
                                       illum_chan, rect_en};
          `RMPC_OFS_DEPTH: o_prdata <= {depth_upper_bound, depth_lower_bound};
          `RMPC_OFS_FOCAL: o_prdata <= {16'h0000, focal_len};
          `RMPC_OFS_CENTER: o_prdata <= {center_y, center_x};
          `RMPC_OFS_FRM_DLY: o_prdata <= frm_delay;
          `RMPC_OFS_PKT_GAP: o_prdata <= {16'h0000, pkt_gap};
          `RMPC_OFS_STATUS: o_prdata <= {frame_count, 13'h0000, o_pkt_go,
                                         tx_state};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Frame-start shadow of depth and optics settings
  // --------------------------------------------------------------------
  rmpc_word16_t sh_lower;
  rmpc_word16_t sh_span;
  rmpc_word16_t sh_focal;
  rmpc_word16_t sh_cx;
  rmpc_word16_t sh_cy;
  logic sh_rect;

  // Sampling at frame start keeps one frame self-consistent even if
  // software rewrites the bounds in mid-frame.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_lower <= `RMPC_RST_LOWER;
      sh_span <= 16'h0000;
      sh_focal <= `RMPC_RST_FOCAL;
      sh_cx <= `RMPC_RST_CX;
      sh_cy <= `RMPC_RST_CY;
      sh_rect <= 1'b0;
    end else if (i_pix_valid && i_pix_sof) begin
      sh_lower <= depth_lower_bound;
      sh_span <= depth_upper_bound - depth_lower_bound;
      sh_focal <= focal_len;
      sh_cx <= center_x;
      sh_cy <= center_y;
      sh_rect <= rect_en;
    end
  end

  // The start-of-frame pixel itself must already use the new settings.
  rmpc_word16_t cur_lower;
  rmpc_word16_t cur_span;
  assign cur_lower = i_pix_sof ? depth_lower_bound : sh_lower;
  assign cur_span = i_pix_sof ? depth_upper_bound - depth_lower_bound
                              : sh_span;

  // --------------------------------------------------------------------
  // Pixel pipeline, four stages
  // --------------------------------------------------------------------
  logic [3:0] vld;
  logic [31:0] s1_prod;
  rmpc_word16_t s1_lower, s1_span, s1_col, s1_row, s2_col, s2_row;
  rmpc_word16_t s2_dist, s2_lower, s2_span;
  logic [31:0] s3_d32;
  logic signed [16:0] s3_du, s3_dv;
  rmpc_word16_t s3_dist;
  logic [31:0] q_sum;

  // Exact floor(p / 65535) for any 16-by-16-bit product p.
  assign q_sum = s1_prod + {16'h0000, s1_prod[31:16]} + 32'h0000_0001;

  // Valid strobe travels with the data, one pixel per clock.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vld <= 4'h0;
    end else begin
      vld <= {vld[2:0], i_pix_valid};
    end
  end

  // Stage 1: sample times span.
  always_ff @(posedge i_clk) begin
    s1_prod <= i_pix_data * cur_span;
    s1_lower <= cur_lower;
    s1_span <= cur_span;
    s1_col <= i_pix_col;
    s1_row <= i_pix_row;
  end

  // Stage 2: distance or Z in mm, radial unless rectified upstream.
  always_ff @(posedge i_clk) begin
    s2_dist <= s1_lower + q_sum[31:16];
    s2_lower <= s1_lower;
    s2_span <= s1_span;
    s2_col <= s1_col;
    s2_row <= s1_row;
  end

  // Stage 3: offset depth rescaled to full range; optical offsets.
  always_ff @(posedge i_clk) begin
    if (s2_span == 16'h0000) begin
      s3_d32 <= 32'hffff_ffff;
    end else begin
      s3_d32 <= ({16'h0000, s2_dist - s2_lower} * 32'h0000_ffff) /
                {16'h0000, s2_span};
    end
    s3_dist <= s2_dist;
    s3_du <= $signed({1'b0, s2_col}) - $signed({1'b0, sh_cx});
    s3_dv <= $signed({1'b0, s2_row}) - $signed({1'b0, sh_cy});
  end

  // Colour word from the saturated scaled depth.
  rmpc_word16_t scaled_depth_word;
  logic [7:0] ramp;
  logic [1:0] band;
  logic [23:0] cword;
  assign scaled_depth_word = (s3_d32 > {16'h0000, `RMPC_FULL_SCALE}) ?
                             `RMPC_FULL_SCALE : s3_d32[15:0];
  assign ramp = scaled_depth_word[13:6];
  assign band = scaled_depth_word[15:14];

  always_comb begin
    cword = {8'h00, ramp, 8'hff};
    if (band[0]) begin
      cword = ((~cword) >> 8) & 24'h00ffff;
    end
    if (band[1]) begin
      cword = cword << 8;
    end
  end

  // X and Y numerators, signed offset times Z.
  logic signed [33:0] num_x, num_y;
  logic signed [33:0] den_f;
  assign num_x = s3_du * $signed({1'b0, s3_dist});
  assign num_y = s3_dv * $signed({1'b0, s3_dist});
  assign den_f = $signed({18'h00000, sh_focal});

  // Stage 4: registered outputs. A zero focal length yields zero X, Y.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pix_valid <= 1'b0;
      o_xyz_valid <= 1'b0;
      o_range_mm <= 16'h0000;
      o_red <= 8'h00;
      o_green <= 8'h00;
      o_blue <= 8'h00;
      o_x <= 32'sh0000_0000;
      o_y <= 32'sh0000_0000;
      o_z <= 32'h0000_0000;
    end else begin
      o_pix_valid <= vld[2];
      o_xyz_valid <= vld[2] & sh_rect;
      o_range_mm <= s3_dist;
      o_red <= cword[7:0];
      o_green <= cword[15:8];
      o_blue <= cword[23:16];
      o_z <= sh_rect ? {16'h0000, s3_dist} : 32'h0000_0000;
      if (sh_rect && sh_focal != 16'h0000) begin
        o_x <= 32'(num_x / den_f);
        o_y <= 32'(num_y / den_f);
      end else begin
        o_x <= 32'sh0000_0000;
        o_y <= 32'sh0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------
  // Frame transmit delay
  // --------------------------------------------------------------------
  logic [31:0] dly_cnt;
  logic [31:0] tick_step;
  rmpc_tx_state_t next_tx_state;

  // One clock is 5 ticks of 1 ns with time sync on, else one tick.
  assign tick_step = time_sync_enable ? 32'(`RMPC_TICKS_PER_CLK)
                                      : 32'h0000_0001;

  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      RMPC_TX_IDLE: if (i_frame_done) next_tx_state = RMPC_TX_DELAY;
      RMPC_TX_DELAY: if (dly_cnt <= tick_step) next_tx_state = RMPC_TX_START;
      RMPC_TX_START: next_tx_state = RMPC_TX_IDLE;
      default: next_tx_state = RMPC_TX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state <= RMPC_TX_IDLE;
      dly_cnt <= 32'h0000_0000;
      o_frame_tx_start <= 1'b0;
      frame_count <= 16'h0000;
    end else begin
      tx_state <= next_tx_state;
      o_frame_tx_start <= (next_tx_state == RMPC_TX_START);
      if (tx_state == RMPC_TX_IDLE && i_frame_done) begin
        dly_cnt <= frm_delay;
      end else if (tx_state == RMPC_TX_DELAY) begin
        dly_cnt <= (dly_cnt > tick_step) ? dly_cnt - tick_step
                                         : 32'h0000_0000;
      end
      if (next_tx_state == RMPC_TX_START) begin
        frame_count <= frame_count + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Inter-packet gap
  // --------------------------------------------------------------------
  rmpc_word16_t gap_cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_cnt <= 16'h0000;
      o_pkt_go <= 1'b0;
    end else if (i_pkt_sent) begin
      gap_cnt <= pkt_gap;
      o_pkt_go <= (pkt_gap == 16'h0000);
    end else if (gap_cnt != 16'h0000) begin
      gap_cnt <= gap_cnt - 16'h0001;
      o_pkt_go <= (gap_cnt == 16'h0001);
    end else begin
      o_pkt_go <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Illumination channels
  // --------------------------------------------------------------------
  logic [7:0] illum_div;
  logic illum_en;
  logic [15:0] lfsr [4];
  assign illum_en = (illum_div == 8'(`RMPC_ILLUM_DIV - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      illum_div <= 8'h00;
    end else begin
      illum_div <= illum_en ? 8'h00 : illum_div + 8'h01;
    end
  end

  // Distinct seeds and taps give each channel its own pseudo-random
  // pulse train, so neighbours look like uncorrelated ambient light.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      localparam logic [15:0] SEED = 16'hace1 ^ (16'h1357 << g);
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          lfsr[g] <= SEED;
        end else if (illum_en) begin
          lfsr[g] <= {lfsr[g][14:0], lfsr[g][15] ^ lfsr[g][13 - g] ^
                      lfsr[g][12] ^ lfsr[g][10]};
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_illum_pulse <= 1'b0;
    end else begin
      o_illum_pulse <= lfsr[illum_chan][0];
    end
  end

endmodule : rmpc_top

`default_nettype wire

// ---- test/rmpc_properties.sv ----
`timescale 1ns/100ps
`default_nettype none

// ------------------------
// Port checker
// ------------------------
module rmpc_properties (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register bus.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Pixel stream.
  input wire logic i_pix_valid,
  input wire logic o_pix_valid,
  input wire logic [7:0] o_red,
  input wire logic [7:0] o_green,
  input wire logic [7:0] o_blue,
  input wire logic o_xyz_valid,
  input wire logic signed [31:0] o_x,
  input wire logic signed [31:0] o_y,
  // Transmit pacing.
  input wire logic i_frame_done,
  input wire logic o_frame_tx_start
);
  // One clock domain, so every check shares clock and reset.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Zero wait states: the access cycle always carries the answer.
  bus_answer_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready in access cycle");
  bus_single_a: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  bus_error_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  pix_latency_a: assert property (i_pix_valid |-> ##4 o_pix_valid)
    else $error("pixel output late or lost");
  pix_cause_a: assert property (
    o_pix_valid |-> $past(i_pix_valid, 4))
    else $error("pixel output without input");
  // Every band keeps one channel full and one channel empty.
  colour_band_a: assert property (o_pix_valid |->
    (o_red == 8'hff && o_blue == 8'h00) ||
    (o_green == 8'hff && o_blue == 8'h00) ||
    (o_red == 8'h00 && o_green == 8'hff) ||
    (o_red == 8'h00 && o_blue == 8'hff))
    else $error("colour outside the four bands");
  xyz_strobe_a: assert property (o_xyz_valid |-> o_pix_valid)
    else $error("coordinates without pixel");
  xyz_quiet_a: assert property (o_pix_valid && !o_xyz_valid |->
    o_x == 32'h0 && o_y == 32'h0)
    else $error("coordinates while rectification off");
  start_pulse_a: assert property (
    o_frame_tx_start |=> !o_frame_tx_start)
    else $error("frame start longer than a cycle");
  start_wait_a: assert property (i_frame_done |=> !o_frame_tx_start)
    else $error("frame start without delay");
endmodule : rmpc_properties

bind rmpc_top rmpc_properties rmpc_properties_i (.i_clk, .i_rst_n, .i_psel,
  .i_penable, .o_pready, .o_pslverr, .i_pix_valid, .o_pix_valid, .o_red,
  .o_green, .o_blue, .o_xyz_valid, .o_x, .o_y, .i_frame_done,
  .o_frame_tx_start);

`default_nettype wire

// ---- test/rmpc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ------------------------
// Host consumer model
// ------------------------
module rmpc_host_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pacing from the device.
  input wire logic i_pkt_go,
  input wire logic i_slow,
  // Packet completion.
  output logic o_pkt_sent
);
  logic [3:0] idle_cnt;

  // Sends only while allowed; slow mode idles seven cycles first.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_cnt <= 4'h0;
      o_pkt_sent <= 1'b0;
    end else begin
      o_pkt_sent <= 1'b0;
      if (!i_pkt_go || o_pkt_sent) begin
        idle_cnt <= 4'h0;
      end else if (idle_cnt < (i_slow ? 4'h7 : 4'h0)) begin
        idle_cnt <= idle_cnt + 4'h1;
      end else begin
        o_pkt_sent <= 1'b1;
      end
    end
  end
endmodule : rmpc_host_model

`default_nettype wire

// ---- test/test_rmpc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rmpc_map.svh"

// ------------------------
// Converter bench
// ------------------------
module test_rmpc_top;
  import rmpc_pkg::*;
  typedef struct {
    logic [15:0] s, c, r, mm;
    logic [23:0] rgb;
    logic [31:0] x, y;
  } rmpc_row_t;
  logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd, o_z;
  logic o_pready, o_pslverr, err, i_conn_close = 0, i_pix_valid = 0;
  logic i_pix_sof = 0, o_pix_valid, o_xyz_valid, i_frame_done = 0;
  logic i_pkt_sent, o_frame_tx_start, o_pkt_go, o_illum_pulse, slow = 0;
  rmpc_word16_t i_pix_data = 16'h0, i_pix_col = 16'h0, i_pix_row = 16'h0;
  rmpc_word16_t o_range_mm;
  logic [7:0] o_red, o_green, o_blue;
  logic signed [31:0] o_x, o_y;
  logic [31:0] sig [4];
  int err_total = 0, samples_checked = 0, cyc = 0, low = 0, last = 0;
  int n0, n1, n2, n3;
  // Expected pixels: lower 0, upper 0xffff, rectified; then span 1000..3000.
  rmpc_row_t rows [8] = '{
    '{16'h0000, 16'h140, 16'h0f0, 16'h0000, 24'h0000ff, 32'h0, 32'h0},
    '{16'h0040, 16'h000, 16'h000, 16'h0040, 24'h0001ff, 32'hffffffb0,
      32'hffffffc4},
    '{16'h4000, 16'h240, 16'h2f0, 16'h4000, 24'h00ffff, 32'h4000, 32'h8000},
    '{16'h8040, 16'h141, 16'h0ef, 16'h8040, 24'h01ff00, 32'h80, 32'hffffff80},
    '{16'hffff, 16'h14a, 16'h0f0, 16'hffff, 24'hff0000, 32'h9ff, 32'h0},
    '{16'hc000, 16'h140, 16'h000, 16'hc000, 24'hffff00, 32'h0, 32'hffff4c00},
    '{16'h8000, 16'h240, 16'h000, 16'h07d0, 24'h00ff00, 32'h0, 32'h0},
    '{16'hffff, 16'h000, 16'h000, 16'h0bb8, 24'hff0000, 32'h0, 32'h0}};

  rmpc_top rmpc_top_i (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_conn_close,
    .i_pix_valid, .i_pix_sof, .i_pix_data, .i_pix_col, .i_pix_row,
    .o_pix_valid, .o_range_mm, .o_red, .o_green, .o_blue, .o_xyz_valid, .o_x,
    .o_y, .o_z, .i_frame_done, .i_pkt_sent, .o_frame_tx_start, .o_pkt_go,
    .o_illum_pulse);
  rmpc_host_model rmpc_host_model_i (.i_clk, .i_rst_n, .i_pkt_go(o_pkt_go),
    .i_slow(slow), .o_pkt_sent(i_pkt_sent));

  // Clock, hang guard and a monitor of the last idle run on packet pacing.
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    low <= o_pkt_go ? 0 : low + 1;
    if (o_pkt_go && low != 0) last <= low;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  // Holds the request until ready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // Streams rows back to back while a second branch checks the outputs.
  task automatic stream(input int lo, hi);
    @(posedge i_clk);
    fork
      begin
        for (int k = lo; k <= hi; k++) begin
          i_pix_valid <= 1'b1;
          i_pix_sof <= k == lo;
          i_pix_data <= rows[k].s;
          i_pix_col <= rows[k].c;
          i_pix_row <= rows[k].r;
          @(posedge i_clk);
        end
        i_pix_valid <= 1'b0;
      end
      for (int k = lo; k <= hi; k++) begin
        int n;
        n = 0;
        do @(posedge i_clk); while (o_pix_valid !== 1'b1 && n++ < 20);
        chk("range", o_range_mm, rows[k].mm);
        chk("rgb", {o_blue, o_green, o_red}, rows[k].rgb);
        chk("x", o_x, rows[k].x);
        chk("y", o_y, rows[k].y);
        chk("z", o_z, k < 6 ? {16'h0, rows[k].mm} : 32'h0);
        chk("xyzv", o_xyz_valid, k < 6);
      end
    join
  endtask : stream

  // Cycles from a frame-acquired pulse to the transmit start.
  task automatic fdly(input logic [31:0] d, output int n);
    apb(1, `RMPC_OFS_FRM_DLY, d);
    @(posedge i_clk);
    i_frame_done <= 1'b1;
    @(posedge i_clk);
    i_frame_done <= 1'b0;
    n = 0;
    while (o_frame_tx_start !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
  endtask : fdly

  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // Main sequence.
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(0, `RMPC_OFS_DEPTH, 32'h0);
    chk("depth", rd, 32'h1b58_0000);
    apb(0, `RMPC_OFS_CENTER, 32'h0);
    chk("center", rd, 32'h00f0_0140);
    apb(0, 12'h01c, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1, `RMPC_OFS_DEPTH, 32'hffff_0000);
    apb(1, `RMPC_OFS_CTRL, 32'h1);
    stream(0, 5);
    apb(1, `RMPC_OFS_DEPTH, 32'h0bb8_03e8);
    apb(1, `RMPC_OFS_CTRL, 32'h0);
    stream(6, 7);
    // A tick is one clock without time sync and 1 ns with it.
    fdly(32'd10, n0);
    fdly(32'd3, n1);
    chk("fdly", n0 - n1, 32'd7);
    apb(1, `RMPC_OFS_CTRL, 32'h8);
    fdly(32'd50, n2);
    fdly(32'd12, n3);
    chk("fdly_sync", {n2[15:0], n3[15:0]}, {n0[15:0], n1[15:0]});
    // Four starts counted, scheduler idle, packet gate open with gap 0.
    apb(0, `RMPC_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h0004_0004);
    // Gap difference cancels any fixed offset; the slow host must not matter.
    apb(1, `RMPC_OFS_PKT_GAP, 32'd6);
    repeat (40) @(posedge i_clk);
    n0 = last;
    slow <= 1'b1;
    apb(1, `RMPC_OFS_PKT_GAP, 32'd10);
    repeat (60) @(posedge i_clk);
    chk("gap", last - n0, 32'd4);
    for (int c = 0; c < 4; c++) begin
      apb(1, `RMPC_OFS_CTRL, 32'h8 | (c << 1));
      for (int i = 0; i < 32; i++) begin
        repeat (10) @(posedge i_clk);
        sig[c][i] = o_illum_pulse;
      end
      chk("illum_act", sig[c] != 32'h0 && sig[c] != 32'hffff_ffff, 32'h1);
    end
    for (int a = 0; a < 4; a++)
      for (int b = a + 1; b < 4; b++)
        chk("illum", sig[a] === sig[b], 32'h0);
    apb(1, `RMPC_OFS_CTRL, 32'hf);
    @(posedge i_clk);
    i_conn_close <= 1'b1;
    @(posedge i_clk);
    i_conn_close <= 1'b0;
    apb(0, `RMPC_OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h8);
    apb(0, `RMPC_OFS_DEPTH, 32'h0);
    chk("depth", rd, 32'h1b58_0000);
    // Of a power cycle and a connection close, only the power cycle clears time sync.
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("rst_go", o_pkt_go, 32'h0);
    i_rst_n <= 1'b1;
    apb(0, `RMPC_OFS_CTRL, 32'h0);
    chk("ctrl_rst", rd, 32'h0);
    test_done();
  end
endmodule : test_rmpc_top

`default_nettype wire
